/* chsi_pkg.sv */
// Package with register map, flag layout and event carriers of the status and interrupt block
package chsi_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_PRIMARY_STATUS   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SECONDARY_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK         = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FIFO_CONTROL     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RX_DATA          = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RX_DATA_ALIAS    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TX_DATA          = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_COMMAND          = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_BLOCK_LENGTH     = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_BLOCK_COUNT      = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_BLOCKS_LEFT      = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_RESP_TIMEOUT     = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_READ_TIMEOUT     = 8'h30;

  // Primary status flag positions, shared by the mask register
  localparam int FLAG_N          = 13;
  localparam int BIT_DATA_DONE   = 0;
  localparam int BIT_BUSY_DONE   = 1;
  localparam int BIT_RESP_DONE   = 2;
  localparam int BIT_READ_TOUT   = 3;
  localparam int BIT_RESP_TOUT   = 4;
  localparam int BIT_WRITE_CRC   = 5;
  localparam int BIT_READ_CRC    = 6;
  localparam int BIT_RESP_CRC    = 7;
  localparam int BIT_TX_READY    = 8;
  localparam int BIT_RX_READY    = 9;
  localparam int BIT_DAT3_EDGE   = 10;
  localparam int BIT_XFER_DONE   = 11;
  localparam int BIT_SPARE       = 12;

  // Secondary status bit positions
  localparam int SEC_N           = 4;
  localparam int SEC_CARD_BUSY   = 0;
  localparam int SEC_TX_EMPTY    = 1;
  localparam int SEC_RX_FULL     = 2;
  localparam int SEC_CLK_STOPPED = 3;

  // FIFO control fields
  localparam int FIFO_CTL_W   = 2;
  localparam int FCTL_DIR_TX  = 0;
  localparam int FCTL_LEVEL   = 1;

  // Command register field
  localparam int CMD_W        = 1;
  localparam int CMD_BUSY_EXP = 0;

  // Thresholds in bytes: 256-bit and 512-bit chunks
  localparam int FIFO_CNT_W = 8;
  localparam logic [FIFO_CNT_W-1:0] THRESH_LOW  = 8'h20;
  localparam logic [FIFO_CNT_W-1:0] THRESH_HIGH = 8'h40;

  localparam int BLEN_W     = 12;
  localparam int BCNT_W     = 16;
  localparam int RESP_TO_W  = 8;
  localparam int READ_TO_W  = 16;

  localparam logic [FLAG_N-1:0]     MASK_RESET  = 13'h0000;
  localparam logic [BLEN_W-1:0]     BLEN_RESET  = 12'h200;
  localparam logic [BCNT_W-1:0]     BCNT_RESET  = 16'h0000;
  localparam logic [RESP_TO_W-1:0]  RTO_RESET   = 8'h00;
  localparam logic [READ_TO_W-1:0]  DTO_RESET   = 16'h0000;

  // Events and levels from the command/data engine, same clock
  typedef struct packed {
    logic respOk;
    logic cmdNoRespDone;
    logic respCrcErr;
    logic readCrcErr;
    logic writeCrcErr;
    logic waitResp;
    logic waitRead;
    logic rxByte;
    logic txByteToShift;
    logic readCrcOk;
    logic writeSendDone;
    logic xferStart;
    logic txShiftEmpty;
    logic rxShiftFull;
    logic clockStopped;
  } chsi_core_ev_s;

  // Requests to the DMA controller and FIFO
  typedef struct packed {
    logic dmaRxReq;
    logic dmaTxReq;
    logic fifoPop;
    logic fifoPush;
  } chsi_fifo_req_s;

endpackage : chsi_pkg

/* chsi_sync_edge.sv */
// Two-stage synchroniser with edge detection for card-side pins
`timescale 1ns/10ps
module chsi_sync_edge
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta;
  logic prev;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      meta  <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      meta  <= pinIn;
      level <= meta;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      prev <= 1'b0;
    else
      prev <= level;
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule : chsi_sync_edge

/* chsi_timeout.sv */
// Wait-time counter in memory clock ticks; zero limit waits forever
`timescale 1ns/10ps
module chsi_timeout
#(
  parameter int W = 8
)
(
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic         waiting,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  output logic              expired
);

  logic [W-1:0] count;
  logic         fired;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b || !waiting)
      count <= '0;
    else if (tick && count != limit)
      count <= count + 1'b1;
  end

  // One pulse per wait, none when the limit is zero
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || !waiting)
    begin
      fired   <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (!fired && limit != '0 && count == limit)
      begin
        fired   <= 1'b1;
        expired <= 1'b1;
      end
    end
  end

endmodule : chsi_timeout

/* chsi_status_irq.sv */
// Status flags, interrupt merge, DMA requests and block counting of the card host
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/10ps
module chsi_status_irq
(
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [chsi_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [chsi_pkg::DATA_W-1:0]   pwdata,
  output logic      [chsi_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire chsi_pkg::chsi_core_ev_s       coreEv,
  input  wire logic [chsi_pkg::FIFO_CNT_W-1:0] fifoCount,
  input  wire logic [chsi_pkg::DATA_W-1:0]   fifoRdData,
  output logic      [chsi_pkg::DATA_W-1:0]   fifoWrData,
  output chsi_pkg::chsi_fifo_req_s           fifoReq,
  input  wire logic                          card_clock_pin,
  input  wire logic                          card_data_line0,
  input  wire logic                          card_data_line3,
  output logic                               busyExpected,
  output logic                               irq
);

  import chsi_pkg::*;

  logic [FLAG_N-1:0]     primary_status_reg;
  logic [FLAG_N-1:0]     irq_mask_reg;
  logic [FIFO_CTL_W-1:0] fifo_control_reg;
  logic [CMD_W-1:0]      command_reg;
  logic [BLEN_W-1:0]     block_length_reg;
  logic [BCNT_W-1:0]     block_count_reg;
  logic [BCNT_W-1:0]     blocks_left_counter;
  logic [RESP_TO_W-1:0]  response_timeout_reg;
  logic [READ_TO_W-1:0]  read_timeout_reg;
  logic [SEC_N-1:0]      secondary_status_reg;

  logic [FLAG_N-1:0]     setVec;
  logic [FLAG_N-1:0]     clrVec;
  logic [FLAG_N-1:0]     next_status;
  logic [BLEN_W-1:0]     byteCount;
  logic                  blocksActive;
  logic                  busyArmed;
  logic                  xferSeen;
  logic                  rxAbove;
  logic                  rxAbovePrev;
  logic                  txBelow;
  logic                  txBelowPrev;
  logic [FIFO_CNT_W-1:0] threshold;

  logic setup;
  logic wrAcc;
  logic rdAcc;
  logic mapped;
  logic cardClkRise;
  logic cardBusy;
  logic dat3Rise;
  logic dat3Fall;
  logic respTimeout;
  logic readTimeout;
  logic txMode;
  logic byteMoved;
  logic blockEnd;
  logic lastByte;
  logic rxReadyEv;
  logic txReadyEv;
  logic busyDoneEv;
  logic dataDoneEv;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = a == OFS_PRIMARY_STATUS || a == OFS_SECONDARY_STATUS || a == OFS_IRQ_MASK ||
               a == OFS_FIFO_CONTROL || a == OFS_RX_DATA || a == OFS_RX_DATA_ALIAS ||
               a == OFS_TX_DATA || a == OFS_COMMAND || a == OFS_BLOCK_LENGTH ||
               a == OFS_BLOCK_COUNT || a == OFS_BLOCKS_LEFT || a == OFS_RESP_TIMEOUT ||
               a == OFS_READ_TIMEOUT;
  endfunction : isMapped

  function automatic logic isRxData(input logic [ADDR_W-1:0] a);
    isRxData = a == OFS_RX_DATA || a == OFS_RX_DATA_ALIAS;
  endfunction : isRxData

  // Card-side pins are sampled through two flip-flops
  chsi_sync_edge uClkSync
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pinIn    (card_clock_pin),
    .level    (),
    .rise     (cardClkRise),
    .fall     ()
  );

  chsi_sync_edge uBusySync
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pinIn    (~card_data_line0),
    .level    (cardBusy),
    .rise     (),
    .fall     ()
  );

  chsi_sync_edge uDat3Sync
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pinIn    (card_data_line3),
    .level    (),
    .rise     (dat3Rise),
    .fall     (dat3Fall)
  );

  chsi_timeout #(.W(RESP_TO_W)) uRespTimeout
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .waiting  (coreEv.waitResp),
    .tick     (cardClkRise),
    .limit    (response_timeout_reg),
    .expired  (respTimeout)
  );

  chsi_timeout #(.W(READ_TO_W)) uReadTimeout
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .waiting  (coreEv.waitRead),
    .tick     (cardClkRise),
    .limit    (read_timeout_reg),
    .expired  (readTimeout)
  );

  // Bus decode
  assign setup   = psel & ~penable;
  assign wrAcc   = psel & penable & pwrite;
  assign rdAcc   = psel & penable & ~pwrite;
  assign mapped  = isMapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      irq_mask_reg         <= MASK_RESET;
      fifo_control_reg     <= '0;
      command_reg          <= '0;
      block_length_reg     <= BLEN_RESET;
      block_count_reg      <= BCNT_RESET;
      response_timeout_reg <= RTO_RESET;
      read_timeout_reg     <= DTO_RESET;
    end
    else if (wrAcc)
    begin
      unique case (paddr)
        OFS_IRQ_MASK:      irq_mask_reg         <= pwdata[FLAG_N-1:0];
        OFS_FIFO_CONTROL:  fifo_control_reg     <= pwdata[FIFO_CTL_W-1:0];
        OFS_COMMAND:       command_reg          <= pwdata[CMD_W-1:0];
        OFS_BLOCK_LENGTH:  block_length_reg     <= pwdata[BLEN_W-1:0];
        OFS_BLOCK_COUNT:   block_count_reg      <= pwdata[BCNT_W-1:0];
        OFS_RESP_TIMEOUT:  response_timeout_reg <= pwdata[RESP_TO_W-1:0];
        OFS_READ_TIMEOUT:  read_timeout_reg     <= pwdata[READ_TO_W-1:0];
        default:           ;
      endcase
    end
  end

  // Read data is prepared in the setup cycle and stands through the access
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      prdata <= '0;
    else if (setup && !pwrite)
    begin
      prdata <= '0;
      unique case (paddr)
        OFS_PRIMARY_STATUS:   prdata[FLAG_N-1:0]    <= primary_status_reg;
        OFS_SECONDARY_STATUS: prdata[SEC_N-1:0]     <= secondary_status_reg;
        OFS_IRQ_MASK:         prdata[FLAG_N-1:0]    <= irq_mask_reg;
        OFS_FIFO_CONTROL:     prdata[FIFO_CTL_W-1:0] <= fifo_control_reg;
        OFS_RX_DATA,
        OFS_RX_DATA_ALIAS:    prdata                <= fifoRdData;
        OFS_COMMAND:          prdata[CMD_W-1:0]     <= command_reg;
        OFS_BLOCK_LENGTH:     prdata[BLEN_W-1:0]    <= block_length_reg;
        OFS_BLOCK_COUNT:      prdata[BCNT_W-1:0]    <= block_count_reg;
        OFS_BLOCKS_LEFT:      prdata[BCNT_W-1:0]    <= blocks_left_counter;
        OFS_RESP_TIMEOUT:     prdata[RESP_TO_W-1:0] <= response_timeout_reg;
        OFS_READ_TIMEOUT:     prdata[READ_TO_W-1:0] <= read_timeout_reg;
        default:              ;
      endcase
    end
  end

  // Transmit data goes to the FIFO with a one-cycle push
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      fifoWrData <= '0;
    else if (wrAcc && paddr == OFS_TX_DATA)
      fifoWrData <= pwdata;
  end

  assign busyExpected = command_reg[CMD_BUSY_EXP];
  assign txMode       = fifo_control_reg[FCTL_DIR_TX];
  assign threshold    = fifo_control_reg[FCTL_LEVEL] ? THRESH_HIGH : THRESH_LOW;

  // Threshold crossings give one event per chunk
  assign rxAbove   = ~txMode & (fifoCount > threshold);
  assign txBelow   = txMode & (fifoCount < threshold);
  assign rxReadyEv = rxAbove & ~rxAbovePrev;
  assign txReadyEv = txBelow & ~txBelowPrev;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rxAbovePrev <= 1'b0;
      txBelowPrev <= 1'b0;
    end
    else
    begin
      rxAbovePrev <= rxAbove;
      txBelowPrev <= txBelow;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      fifoReq <= '0;
    else
    begin
      fifoReq.dmaRxReq <= rxReadyEv;
      fifoReq.dmaTxReq <= txReadyEv;
      fifoReq.fifoPop  <= rdAcc & isRxData(paddr);
      fifoReq.fifoPush <= wrAcc & (paddr == OFS_TX_DATA);
    end
  end

  // Byte and block counting for the transfer-done event
  assign byteMoved = txMode ? coreEv.txByteToShift : coreEv.rxByte;
  assign blockEnd  = byteMoved & (byteCount == block_length_reg - 1'b1);
  assign lastByte  = blockEnd & blocksActive & (blocks_left_counter == BCNT_W'(1));

  always_ff @(posedge core_clk)
  begin
    if (!rst_b || coreEv.xferStart)
      byteCount <= '0;
    else if (blockEnd)
      byteCount <= '0;
    else if (byteMoved)
      byteCount <= byteCount + 1'b1;
  end

  // Zero block count means open-ended transfer with no transfer-done
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      blocks_left_counter <= '0;
      blocksActive        <= 1'b0;
    end
    else if (coreEv.xferStart)
    begin
      blocks_left_counter <= block_count_reg;
      blocksActive        <= block_count_reg != '0;
    end
    else if (blockEnd && blocksActive)
    begin
      blocks_left_counter <= blocks_left_counter - 1'b1;
      blocksActive        <= blocks_left_counter != BCNT_W'(1);
    end
  end

  // Data-done only after transfer-done and the CRC or programming phase
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || coreEv.xferStart)
      xferSeen <= 1'b0;
    else if (lastByte)
      xferSeen <= 1'b1;
    else if (dataDoneEv)
      xferSeen <= 1'b0;
  end

  assign dataDoneEv = xferSeen & (txMode ? coreEv.writeSendDone & ~cardBusy
                                         : coreEv.readCrcOk);

  // Busy check armed by the end of the command when busy is expected
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      busyArmed <= 1'b0;
    else if (busyExpected && (coreEv.respOk || coreEv.cmdNoRespDone))
      busyArmed <= 1'b1;
    else if (busyDoneEv || !busyExpected)
      busyArmed <= 1'b0;
  end

  assign busyDoneEv = busyArmed & busyExpected & ~cardBusy;

  always_comb
  begin
    setVec                = '0;
    setVec[BIT_DATA_DONE] = dataDoneEv;
    setVec[BIT_BUSY_DONE] = busyDoneEv;
    setVec[BIT_RESP_DONE] = coreEv.respOk | coreEv.cmdNoRespDone;
    setVec[BIT_READ_TOUT] = readTimeout;
    setVec[BIT_RESP_TOUT] = respTimeout;
    setVec[BIT_WRITE_CRC] = coreEv.writeCrcErr;
    setVec[BIT_READ_CRC]  = coreEv.readCrcErr;
    setVec[BIT_RESP_CRC]  = coreEv.respCrcErr;
    setVec[BIT_TX_READY]  = txReadyEv;
    setVec[BIT_RX_READY]  = rxReadyEv;
    setVec[BIT_DAT3_EDGE] = dat3Rise | dat3Fall;
    setVec[BIT_XFER_DONE] = lastByte;
  end

  always_comb
  begin
    clrVec = '0;
    // Clears what the read returned, so a flag set in the setup cycle is not lost
    if (rdAcc && paddr == OFS_PRIMARY_STATUS)
      clrVec = prdata[FLAG_N-1:0];
    if (rdAcc && isRxData(paddr))
      clrVec[BIT_RX_READY] = 1'b1;
    if (wrAcc && paddr == OFS_TX_DATA)
      clrVec[BIT_TX_READY] = 1'b1;
  end

  // Sticky flags, a set in the clearing cycle wins
  assign next_status = (primary_status_reg & ~clrVec) | setVec;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      primary_status_reg <= '0;
    else
      primary_status_reg <= next_status;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      secondary_status_reg <= '0;
    else
    begin
      secondary_status_reg[SEC_CARD_BUSY]   <= cardBusy;
      secondary_status_reg[SEC_TX_EMPTY]    <= coreEv.txShiftEmpty;
      secondary_status_reg[SEC_RX_FULL]     <= coreEv.rxShiftFull;
      secondary_status_reg[SEC_CLK_STOPPED] <= coreEv.clockStopped;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(primary_status_reg & irq_mask_reg);
  end

endmodule : chsi_status_irq

/* chsi_status_irq_properties.sv */
// Port-level checker of the status and interrupt block
`timescale 1ns/10ps
module chsi_status_irq_properties
(
  input wire logic                         core_clk,
  input wire logic                         rst_b,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [chsi_pkg::ADDR_W-1:0]  paddr,
  input wire logic [chsi_pkg::DATA_W-1:0]  pwdata,
  input wire logic [chsi_pkg::DATA_W-1:0]  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire chsi_pkg::chsi_fifo_req_s     fifoReq,
  input wire logic                         busyExpected,
  input wire logic                         irq
);
  import chsi_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  logic acc;
  assign acc = psel && penable;

  ready_zero_wait_a: assert property (acc |-> pready)
    else $error("access phase without ready");
  unmapped_refused_a: assert property (acc && paddr > OFS_READ_TIMEOUT |-> pslverr && (pwrite || prdata == '0))
    else $error("unmapped access not refused");
  mapped_no_err_a: assert property (acc && paddr <= OFS_READ_TIMEOUT && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  reset_quiet_a: assert property ($rose(rst_b) |-> !irq && fifoReq == '0 && prdata == '0)
    else $error("outputs not quiet after reset");
  rx_pop_a: assert property (acc && !pwrite && paddr == OFS_RX_DATA |=> fifoReq.fifoPop)
    else $error("rx data read without fifo pop");
  tx_push_a: assert property (acc && pwrite && paddr == OFS_TX_DATA |=> fifoReq.fifoPush)
    else $error("tx data write without fifo push");
  dma_pulse_a: assert property (fifoReq.dmaRxReq || fifoReq.dmaTxReq |=> fifoReq[3:2] == 2'h0)
    else $error("dma request longer than one cycle");
  mask_off_a: assert property (acc && pwrite && paddr == OFS_IRQ_MASK && pwdata[12:0] == '0 |=> ##1 !irq)
    else $error("irq high with all mask bits clear");
  busy_exp_a: assert property (acc && pwrite && paddr == OFS_COMMAND |=> busyExpected == $past(pwdata[0]))
    else $error("busy expected bit not written");

  rx_read_c: cover property (acc && !pwrite && paddr == OFS_RX_DATA);
  dma_c: cover property (fifoReq.dmaRxReq || fifoReq.dmaTxReq);
  irq_c: cover property ($rose(irq));
endmodule : chsi_status_irq_properties

bind chsi_status_irq chsi_status_irq_properties u_props (.core_clk, .rst_b, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fifoReq, .busyExpected, .irq);

/* chsi_card_model.sv */
// Behavioural card seen at the memory clock and data pins
`timescale 1ns/10ps
module chsi_card_model
(
  input  wire logic clkRun,
  input  wire logic cardBusy,
  input  wire logic dat3Level,
  output logic      card_clock_pin,
  output logic      card_data_line0,
  output logic      card_data_line3
);
  initial card_clock_pin = 1'b0;
  // Memory clock runs only within a frame, 400 ns period
  always
  begin
    wait (clkRun);
    // Edges fall between core clock edges to keep sampling free of races
    #180 card_clock_pin = 1'b1;
    #200 card_clock_pin = 1'b0;
    #20;
  end
  // Busy shows as a low line 0, pulled up otherwise
  assign card_data_line0 = !cardBusy;
  assign card_data_line3 = dat3Level;
endmodule : chsi_card_model

/* tb_top.sv */
// Testbench of the status and interrupt block
`timescale 1ns/10ps
module tb_top;
  import chsi_pkg::*;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, busyExpected;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, fifoRdData, fifoWrData, rd;
  logic [FIFO_CNT_W-1:0] fifoCount;
  chsi_core_ev_s coreEv;
  chsi_fifo_req_s fifoReq;
  logic clkRun, cardBusy, dat3Level, pinClk, pinD0, pinD3, err;
  int error_cnt = 0;
  int checked = 0;
  int dmaCnt = 0;
  logic [ADDR_W-1:0] rstA [10] = '{OFS_PRIMARY_STATUS, OFS_SECONDARY_STATUS, OFS_IRQ_MASK,
    OFS_FIFO_CONTROL, OFS_COMMAND, OFS_BLOCK_LENGTH, OFS_BLOCK_COUNT, OFS_BLOCKS_LEFT,
    OFS_RESP_TIMEOUT, OFS_READ_TIMEOUT};
  logic [ADDR_W-1:0] toA [2] = '{OFS_RESP_TIMEOUT, OFS_READ_TIMEOUT};
  int toB [2] = '{BIT_RESP_TOUT, BIT_READ_TOUT};
  // Event bit positions follow the struct order, respOk at 14
  int evB [4] = '{13, 12, 11, 10};
  int flB [4] = '{BIT_RESP_DONE, BIT_RESP_CRC, BIT_READ_CRC, BIT_WRITE_CRC};

  chsi_status_irq dut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .coreEv, .fifoCount, .fifoRdData, .fifoWrData, .fifoReq,
    .card_clock_pin(pinClk), .card_data_line0(pinD0), .card_data_line3(pinD3),
    .busyExpected, .irq);
  chsi_card_model card (.clkRun, .cardBusy, .dat3Level, .card_clock_pin(pinClk),
    .card_data_line0(pinD0), .card_data_line3(pinD3));

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (fifoReq.dmaRxReq || fifoReq.dmaTxReq) dmaCnt++;

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    apb(1'b0, a, '0);
    chk(rd, exp);
  endtask : rdchk

  task automatic pulse(input int b);
    coreEv[b] <= 1'b1;
    @(posedge core_clk);
    coreEv[b] <= 1'b0;
    @(posedge core_clk);
  endtask : pulse

  task automatic print_verdict;
    $display("Errors %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  initial
  begin
    cyc(5000);
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, coreEv, fifoCount} = '0;
    {clkRun, cardBusy, dat3Level, rst_b} = '0;
    fifoRdData = 32'h5A5A_C3C3;
    cyc(8);
    rst_b <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 10; i++)
      rdchk(rstA[i], (rstA[i] == OFS_BLOCK_LENGTH) ? 32'(BLEN_RESET) : '0);
    rdchk(8'h38, '0);
    chk(err, 1'b1);
    apb(1'b1, OFS_BLOCKS_LEFT, 32'h5);
    rdchk(OFS_BLOCKS_LEFT, '0);
    pulse(14);
    cyc(2);
    chk(irq, 0);
    apb(1'b1, OFS_IRQ_MASK, 32'h1 << BIT_RESP_DONE);
    cyc(2);
    chk(irq, 1);
    rdchk(OFS_PRIMARY_STATUS, 32'h1 << BIT_RESP_DONE);
    rdchk(OFS_PRIMARY_STATUS, '0);
    chk(irq, 0);
    apb(1'b1, OFS_IRQ_MASK, 32'h1FFF);
    for (int i = 0; i < 4; i++)
    begin
      pulse(evB[i]);
      cyc(2);
      chk(irq, 1);
      rdchk(OFS_PRIMARY_STATUS, 32'h1 << flB[i]);
    end
    // Timeouts count memory clock rises; period is 8 core cycles
    clkRun <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      coreEv[9-i] <= 1'b1;
      cyc(24);
      rdchk(OFS_PRIMARY_STATUS, '0);
      coreEv[9-i] <= 1'b0;
      apb(1'b1, toA[i], 32'h3);
      coreEv[9-i] <= 1'b1;
      cyc(10);
      rdchk(OFS_PRIMARY_STATUS, '0);
      cyc(18);
      rdchk(OFS_PRIMARY_STATUS, 32'h1 << toB[i]);
      coreEv[9-i] <= 1'b0;
      apb(1'b1, toA[i], '0);
    end
    clkRun <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      dat3Level <= !dat3Level;
      cyc(6);
      rdchk(OFS_PRIMARY_STATUS, 32'h1 << BIT_DAT3_EDGE);
    end
    coreEv[2:0] <= 3'h7;
    apb(1'b1, OFS_COMMAND, 32'h1);
    cardBusy <= 1'b1;
    cyc(4);
    rdchk(OFS_SECONDARY_STATUS, 32'hF);
    pulse(14);
    cyc(4);
    rdchk(OFS_PRIMARY_STATUS, 32'h1 << BIT_RESP_DONE);
    cardBusy <= 1'b0;
    cyc(5);
    rdchk(OFS_PRIMARY_STATUS, 32'h1 << BIT_BUSY_DONE);
    rdchk(OFS_SECONDARY_STATUS, 32'hE);
    coreEv[2:0] <= 3'h0;
    apb(1'b1, OFS_COMMAND, '0);
    fifoCount <= THRESH_LOW;
    cyc(3);
    rdchk(OFS_PRIMARY_STATUS, '0);
    fifoCount <= THRESH_LOW + 8'h01;
    cyc(3);
    chk(irq, 1);
    chk(dmaCnt, 1);
    apb(1'b0, OFS_RX_DATA, '0);
    chk(rd, 32'h5A5A_C3C3);
    rdchk(OFS_PRIMARY_STATUS, '0);
    fifoCount <= THRESH_HIGH;
    apb(1'b1, OFS_FIFO_CONTROL, 32'h3);
    cyc(2);
    chk(irq, 0);
    fifoCount <= THRESH_HIGH - 8'h01;
    cyc(3);
    chk(irq, 1);
    apb(1'b1, OFS_TX_DATA, 32'hA5C3_0F1E);
    chk(fifoWrData, 32'hA5C3_0F1E);
    rdchk(OFS_PRIMARY_STATUS, '0);
    chk(dmaCnt, 2);
    fifoCount <= '0;
    apb(1'b1, OFS_FIFO_CONTROL, '0);
    apb(1'b1, OFS_BLOCK_LENGTH, 32'h4);
    apb(1'b1, OFS_BLOCK_COUNT, 32'h2);
    pulse(3);
    rdchk(OFS_BLOCKS_LEFT, 32'h2);
    for (int i = 0; i < 8; i++)
    begin
      pulse(7);
      if (i == 3)
        rdchk(OFS_BLOCKS_LEFT, 32'h1);
    end
    cyc(2);
    rdchk(OFS_PRIMARY_STATUS, 32'h1 << BIT_XFER_DONE);
    pulse(5);
    cyc(2);
    rdchk(OFS_PRIMARY_STATUS, 32'h1 << BIT_DATA_DONE);
    // Single-block write: send-done before the last byte must not give data-done
    apb(1'b1, OFS_FIFO_CONTROL, 32'h1);
    apb(1'b1, OFS_BLOCK_COUNT, 32'h1);
    pulse(3);
    pulse(4);
    for (int i = 0; i < 4; i++)
      pulse(6);
    rdchk(OFS_PRIMARY_STATUS, (32'h1 << BIT_XFER_DONE) | (32'h1 << BIT_TX_READY));
    apb(1'b1, OFS_COMMAND, '0);
    pulse(4);
    cyc(2);
    rdchk(OFS_PRIMARY_STATUS, 32'h1 << BIT_DATA_DONE);
    print_verdict();
  end
endmodule : tb_top
